// File: core/gpcp_map.vh
// Register offsets, field positions, reset values and timing for the GPIO port block
`ifndef GPCP_MAP_VH
`define GPCP_MAP_VH

// I/O location offsets (4-bit I/O address)
`define GPCP_A_PIN_LO 4'h0
`define GPCP_A_DIR_LO 4'h1
`define GPCP_A_OUT_LO 4'h2
`define GPCP_A_PIN_HI 4'h3
`define GPCP_A_DIR_HI 4'h4
`define GPCP_A_OUT_HI 4'h5
`define GPCP_A_MCUCTL 4'h6
`define GPCP_A_GRPEN 4'h7
`define GPCP_A_FLAGS 4'h8
`define GPCP_A_MASK_LO 4'h9
`define GPCP_A_MASK_HI 4'hA

// Field positions
`define GPCP_F_LOWER 0
`define GPCP_F_UPPER 1
`define GPCP_F_PUD 4

// Reset values
`define GPCP_R_PORT 8'h00
`define GPCP_R_DIR 8'h00
`define GPCP_R_MASK 8'h00
`define GPCP_R_FLAGS 8'h00
`define GPCP_R_GRPEN 8'h00
`define GPCP_R_MCUCTL 8'h00

// Geometry and timing
`define GPCP_NPIN 16
`define GPCP_SYNC_STAGES 3

`endif

// File: core/gpcp_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module gpcp_sync
(
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  input wire ce,
  // Pins
  input wire [15:0] rawIn,
  output reg [15:0] stable_q
);

  reg [15:0] s1_q;
  reg [15:0] s2_q;
  reg [15:0] s3_q;
  integer i;

  // Stage one feeds stage two only; the value moves once stages two and three agree
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
      stable_q <= 16'h0000;
    end
    else if (ce)
    begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < 16; i = i + 1)
      begin
        if (s2_q[i] == s3_q[i])
          stable_q[i] <= s3_q[i];
      end
    end
  end

endmodule

// File: core/gpcp_chg.v
// Pin change detector for the two eight-pin groups
`timescale 1ns/1ns
module gpcp_chg
(
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  input wire ce,
  // Synchronised pins and enables
  input wire [15:0] pinVal,
  input wire [7:0] maskLower,
  input wire [7:0] maskUpper,
  input wire [1:0] groupEn,
  // Group requests
  output wire reqLower,
  output wire reqUpper
);

  reg [15:0] prev_q;
  wire [15:0] diff;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prev_q <= 16'h0000;
    else if (ce)
      prev_q <= pinVal;
  end

  assign diff = pinVal ^ prev_q;
  assign reqLower = ce & groupEn[0] & (|(diff[7:0] & maskLower));
  assign reqUpper = ce & groupEn[1] & (|(diff[15:8] & maskUpper));

endmodule

// File: core/gpcp_port.v
// Two eight-pin GPIO ports with pin-change interrupt groups
`timescale 1ns/1ns
`include "gpcp_map.vh"

// Behaviour
// - Flag register bits 7 to 2 always read as zero.
// - A masked change on pins 8 to 15 sets flag bit 1.
// - A masked change on pins 0 to 7 sets flag bit 0.
// - Group request goes out only with flag, global enable and group enable set.
// - Entering a group's interrupt routine clears that group's flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Upper mask bits enable change detection on pins 8 to 15 with group enable.
// - Lower mask bits enable change detection on pins 0 to 7 with group enable.
// - Single-bit set or clear touches only the addressed bit.
// - Each port has read-write data and direction and read-only input locations.
// - Writing one to an input pin bit inverts that output data bit.
// - The pull-up disable bit turns off every pull-up.
// - Direction one makes the pin an output, zero an input.
// - Input pin with data one gets a pull-up; otherwise pull-up off.
// - Reset tri-states every pin at once, without needing the clock.
// - Output pins drive the output data bit value.
// - Alternate functions on some pins leave the other pins normal GPIO.
// - Control register bit 1 enables upper group, bit 0 lower group.
// - Pin inputs are synchronised before reaching the input register.
module gpcp_port
(
  // Clock, enable and reset
  input wire mclk,
  input wire arst_n,
  input wire ce,
  // I/O location access
  input wire [3:0] ioAddr,
  input wire [7:0] ioWrData,
  input wire ioWr,
  input wire ioSetBit,
  input wire ioClrBit,
  input wire [2:0] ioBitIdx,
  input wire ioRd,
  output reg [7:0] ioRdData_q,
  // Processor interrupt interface
  input wire globalIrqEn,
  input wire vecEnterLower,
  input wire vecEnterUpper,
  output wire irqReqLower,
  output wire irqReqUpper,
  // Alternate function overrides, one bit per pin
  input wire [15:0] altEn,
  input wire [15:0] altOut,
  input wire [15:0] altDrive,
  // Pads
  input wire [15:0] padIn,
  output reg [15:0] padOut,
  output reg [15:0] padOe_n,
  output reg [15:0] padPullUp
);

  reg [15:0] outData_q;
  reg [15:0] dir_q;
  reg [7:0] maskLower_q;
  reg [7:0] maskUpper_q;
  reg [1:0] groupEn_q;
  reg [1:0] flags_q;
  reg [1:0] flags_d;
  reg pullUpDis_q;
  wire [15:0] pinVal;
  wire reqLower;
  wire reqUpper;
  wire bitOp;
  wire [7:0] flagOnes;
  reg [7:0] rdMux;
  wire [7:0] grpMerge;
  wire [7:0] pudMerge;
  wire [15:0] outNext;
  wire [15:0] dirNext;
  integer k;

  // New value of a byte location after a byte write or single-bit set or clear
  function [7:0] wrMerge;
    input [7:0] old;
    input [7:0] data;
    input isByte;
    input isSet;
    input isClr;
    input [2:0] idx;
    begin
      wrMerge = old;
      if (isByte)
        wrMerge = data;
      else if (isSet)
        wrMerge = old | (8'h01 << idx);
      else if (isClr)
        wrMerge = old & ~(8'h01 << idx);
    end
  endfunction

  // Bits written as one, for toggle and write-one-to-clear locations
  function [7:0] onesOf;
    input [7:0] data;
    input isByte;
    input isSet;
    input [2:0] idx;
    begin
      onesOf = 8'h00;
      if (isByte)
        onesOf = data;
      else if (isSet)
        onesOf = 8'h01 << idx;
    end
  endfunction

  assign bitOp = ioSetBit | ioClrBit;
  assign grpMerge = wrMerge({6'b000000, groupEn_q}, ioWrData, ioWr, ioSetBit, ioClrBit,
                            ioBitIdx);
  assign pudMerge = wrMerge({3'b000, pullUpDis_q, 4'h0}, ioWrData, ioWr, ioSetBit,
                            ioClrBit, ioBitIdx);

  gpcp_sync u_sync
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .rawIn(padIn),
    .stable_q(pinVal)
  );

  gpcp_chg u_chg
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .pinVal(pinVal),
    .maskLower(maskLower_q),
    .maskUpper(maskUpper_q),
    .groupEn(groupEn_q),
    .reqLower(reqLower),
    .reqUpper(reqUpper)
  );

  // Per-port data and direction locations
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gPort
      localparam [3:0] ADDR_PIN = (g == 0) ? `GPCP_A_PIN_LO : `GPCP_A_PIN_HI;
      localparam [3:0] ADDR_DIR = (g == 0) ? `GPCP_A_DIR_LO : `GPCP_A_DIR_HI;
      localparam [3:0] ADDR_OUT = (g == 0) ? `GPCP_A_OUT_LO : `GPCP_A_OUT_HI;
      wire hitPin;
      wire hitDir;
      wire hitOut;
      wire [7:0] toggle;

      assign hitPin = ioAddr == ADDR_PIN;
      assign hitDir = ioAddr == ADDR_DIR;
      assign hitOut = ioAddr == ADDR_OUT;
      // A clear-bit on the input location writes a zero, so it toggles nothing
      assign toggle = hitPin ? onesOf(ioWrData, ioWr, ioSetBit, ioBitIdx) : 8'h00;

      // Toggle is zero unless the input location is hit
      assign outNext[g*8 +: 8] = (hitOut && (ioWr || bitOp)) ?
                                 wrMerge(outData_q[g*8 +: 8], ioWrData, ioWr, ioSetBit,
                                         ioClrBit, ioBitIdx) :
                                 outData_q[g*8 +: 8] ^ toggle;
      assign dirNext[g*8 +: 8] = (hitDir && (ioWr || bitOp)) ?
                                 wrMerge(dir_q[g*8 +: 8], ioWrData, ioWr, ioSetBit,
                                         ioClrBit, ioBitIdx) :
                                 dir_q[g*8 +: 8];
    end
  endgenerate

  // One register process for both ports keeps a single driver per register
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outData_q <= {`GPCP_R_PORT, `GPCP_R_PORT};
      dir_q <= {`GPCP_R_DIR, `GPCP_R_DIR};
    end
    else if (ce)
    begin
      outData_q <= outNext;
      dir_q <= dirNext;
    end
  end

  // Control, mask and enable locations
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      maskLower_q <= `GPCP_R_MASK;
      maskUpper_q <= `GPCP_R_MASK;
      groupEn_q <= 2'b00;
      pullUpDis_q <= 1'b0;
    end
    else if (ce)
    begin
      if (ioAddr == `GPCP_A_MASK_LO)
        maskLower_q <= wrMerge(maskLower_q, ioWrData, ioWr, ioSetBit, ioClrBit,
                               ioBitIdx);
      if (ioAddr == `GPCP_A_MASK_HI)
        maskUpper_q <= wrMerge(maskUpper_q, ioWrData, ioWr, ioSetBit, ioClrBit,
                               ioBitIdx);
      if (ioAddr == `GPCP_A_GRPEN)
        groupEn_q <= grpMerge[1:0];
      if (ioAddr == `GPCP_A_MCUCTL)
        pullUpDis_q <= pudMerge[`GPCP_F_PUD];
    end
  end

  // Group flags: hardware set wins over any clear in the same cycle
  assign flagOnes = (ioAddr == `GPCP_A_FLAGS) ?
                    onesOf(ioWrData, ioWr, ioSetBit, ioBitIdx) : 8'h00;

  always @*
  begin
    flags_d = flags_q;
    if (flagOnes[`GPCP_F_LOWER] || vecEnterLower)
      flags_d[`GPCP_F_LOWER] = 1'b0;
    if (flagOnes[`GPCP_F_UPPER] || vecEnterUpper)
      flags_d[`GPCP_F_UPPER] = 1'b0;
    if (reqLower)
      flags_d[`GPCP_F_LOWER] = 1'b1;
    if (reqUpper)
      flags_d[`GPCP_F_UPPER] = 1'b1;
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      flags_q <= 2'b00;
    else if (ce)
      flags_q <= flags_d;
  end

  assign irqReqLower = flags_q[`GPCP_F_LOWER] & groupEn_q[`GPCP_F_LOWER] & globalIrqEn;
  assign irqReqUpper = flags_q[`GPCP_F_UPPER] & groupEn_q[`GPCP_F_UPPER] & globalIrqEn;

  // Read multiplexer; unmapped locations read zero
  always @*
  begin
    case (ioAddr)
      `GPCP_A_PIN_LO: rdMux = pinVal[7:0];
      `GPCP_A_DIR_LO: rdMux = dir_q[7:0];
      `GPCP_A_OUT_LO: rdMux = outData_q[7:0];
      `GPCP_A_PIN_HI: rdMux = pinVal[15:8];
      `GPCP_A_DIR_HI: rdMux = dir_q[15:8];
      `GPCP_A_OUT_HI: rdMux = outData_q[15:8];
      `GPCP_A_MCUCTL: rdMux = {3'b000, pullUpDis_q, 4'h0};
      `GPCP_A_GRPEN: rdMux = {6'b000000, groupEn_q};
      `GPCP_A_FLAGS: rdMux = {6'b000000, flags_q};
      `GPCP_A_MASK_LO: rdMux = maskLower_q;
      `GPCP_A_MASK_HI: rdMux = maskUpper_q;
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ioRdData_q <= 8'h00;
    else if (ce && ioRd)
      ioRdData_q <= rdMux;
  end

  // Pad drivers; reset gating keeps pins released even with the clock stopped
  always @*
  begin
    for (k = 0; k < 16; k = k + 1)
    begin
      if (altEn[k])
      begin
        padOut[k] = altOut[k];
        padOe_n[k] = ~(altDrive[k] & arst_n);
        padPullUp[k] = 1'b0;
      end
      else
      begin
        padOut[k] = outData_q[k];
        padOe_n[k] = ~(dir_q[k] & arst_n);
        padPullUp[k] = ~dir_q[k] & outData_q[k] & ~pullUpDis_q & arst_n;
      end
    end
  end

endmodule

// File: testbench/gpcp_pad_model.sv
// Outside world attached to the port pads
`timescale 1ns/1ns
module gpcp_pad_model
(
  // Pad side of the block
  input logic [15:0] padOut,
  input logic [15:0] padOe_n,
  // Level applied from outside
  input logic [15:0] extVal,
  output logic [15:0] padIn
);
  // A pin the block drives reads back its own level, others follow the source
  assign padIn = (padOut & ~padOe_n) | (extVal & padOe_n);
endmodule

// File: testbench/gpcp_props.sv
// Checker for the GPIO port block pins and bus
`timescale 1ns/1ns
`include "gpcp_map.vh"
module gpcp_props
(
  // Clock, reset, bus
  input logic mclk,
  input logic arst_n,
  input logic ce,
  input logic [3:0] ioAddr,
  input logic [7:0] ioWrData,
  input logic ioWr,
  input logic ioRd,
  input logic [7:0] ioRdData_q,
  // Interrupts
  input logic globalIrqEn,
  input logic vecEnterUpper,
  input logic irqReqLower,
  input logic irqReqUpper,
  // Pads
  input logic [15:0] altEn,
  input logic [15:0] altOut,
  input logic [15:0] padIn,
  input logic [15:0] padOut,
  input logic [15:0] padOe_n,
  input logic [15:0] padPullUp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  oe_reset_a: assert property ($rose(arst_n) |-> padOe_n == 16'hFFFF)
    else $error("pin driven at reset exit");
  pull_input_a: assert property ((padPullUp & (altEn | ~padOe_n)) == 16'h0000)
    else $error("pull-up on driven pin");
  irq_gate_a: assert property (irqReqLower || irqReqUpper |-> globalIrqEn)
    else $error("request without global enable");
  vec_clear_a: assert property ($stable(padIn)[*5] ##0 (ce && vecEnterUpper)
    |=> !irqReqUpper) else $error("flag kept after vector entry");
  wr_clear_a: assert property ($stable(padIn)[*5] ##0 (ce && ioWr &&
    ioAddr == `GPCP_A_FLAGS && ioWrData[0]) |=> !irqReqLower) else $error("flag not cleared");
  flag_rsv_a: assert property (ce && ioRd && ioAddr == `GPCP_A_FLAGS
    |=> ioRdData_q[7:2] == 6'h00) else $error("reserved flag bits set");
  pin_toggle_a: assert property (ce && ioWr && ioAddr == `GPCP_A_PIN_LO && ioWrData[0] &&
    !padOe_n[0] && !altEn[0] |=> padOut[0] != $past(padOut[0])) else $error("no toggle");
  alt_pass_a: assert property (((padOut ^ altOut) & altEn) == 16'h0000)
    else $error("override value lost");
endmodule

bind gpcp_port gpcp_props props_u (.mclk, .arst_n, .ce, .ioAddr, .ioWrData, .ioWr, .ioRd,
  .ioRdData_q, .globalIrqEn, .vecEnterUpper, .irqReqLower, .irqReqUpper, .altEn, .altOut,
  .padIn, .padOut, .padOe_n, .padPullUp);

// File: testbench/tb_gpio_port_with_pin_change_irq.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/1ns
module tb_gpio_port_with_pin_change_irq;
  logic mclk = 0, arst_n = 0, ioWr = 0, ioSetBit = 0, ioClrBit = 0, ioRd = 0;
  logic globalIrqEn = 1, vecEnterLower = 0, vecEnterUpper = 0;
  logic [3:0] ioAddr = 4'h0;
  logic [7:0] ioWrData = 8'h00;
  logic [2:0] ioBitIdx = 3'h0;
  logic [15:0] altEn = 16'h0000, altOut = 16'h0000, altDrive = 16'h0000, extVal = 16'h0000;
  logic [7:0] ioRdData_q;
  logic irqReqLower, irqReqUpper;
  logic [15:0] padIn, padOut, padOe_n, padPullUp, irqs;
  int n_mismatch = 0, samples_checked = 0;
  // Write location, write data, read location, expected read data
  logic [23:0] rows [0:6] = '{
    {4'h1, 8'h0F, 4'h1, 8'h0F},
    {4'h2, 8'hA5, 4'h2, 8'hA5},
    {4'h0, 8'h03, 4'h2, 8'hA6},
    {4'h9, 8'hFF, 4'h9, 8'hFF},
    {4'hA, 8'h3C, 4'hA, 8'h3C},
    {4'h7, 8'h03, 4'h7, 8'h03},
    {4'hB, 8'hFF, 4'hB, 8'h00}
  };
  assign irqs = {14'h0000, irqReqUpper, irqReqLower};
  gpcp_port dut_u (.mclk, .arst_n, .ce(1'b1), .ioAddr, .ioWrData, .ioWr, .ioSetBit, .ioClrBit,
    .ioBitIdx, .ioRd, .ioRdData_q, .globalIrqEn, .vecEnterLower, .vecEnterUpper, .irqReqLower,
    .irqReqUpper, .altEn, .altOut, .altDrive, .padIn, .padOut, .padOe_n, .padPullUp);
  gpcp_pad_model pads_u (.padOut, .padOe_n, .extVal, .padIn);
  always #50 mclk = ~mclk;
  // Strobes k: write, set bit, clear bit, read; d also carries the bit index
  task automatic io(input logic [3:0] k, input logic [3:0] a, input logic [7:0] d);
    {ioWr, ioSetBit, ioClrBit, ioRd} = k;
    ioAddr = a;
    ioWrData = d;
    ioBitIdx = d[2:0];
    @(posedge mclk);
    #1 {ioWr, ioSetBit, ioClrBit, ioRd} = 4'h0;
    // Let an idle edge pass so the next call never reassigns in this time step
    @(posedge mclk);
    #1;
  endtask
  task automatic bad(input string m);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    io(4'h1, a, 8'h00);
    samples_checked++;
    if (ioRdData_q !== e) bad("read data");
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) bad("pad or request level");
  endtask
  // Bounded wait for a request, a flag takes five edges after a pin change
  task automatic w8;
    for (int j = 0; j < 8 && !(irqReqLower || irqReqUpper); j++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    results;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 arst_n = 1;
    chk(padOe_n, 16'hFFFF);
    rdc(4'h8, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      io(4'h8, rows[i][23:20], rows[i][19:12]);
      rdc(rows[i][11:8], rows[i][7:0]);
    end
    io(4'h4, 4'h1, 8'h07);
    io(4'h2, 4'h1, 8'h00);
    rdc(4'h1, 8'h8E);
    chk(padOe_n, 16'hFF71);
    chk(padOut & ~padOe_n, 16'h0086);
    chk(padPullUp, 16'h0020);
    io(4'h8, 4'h6, 8'h10);
    chk(padPullUp, 16'h0000);
    io(4'h8, 4'h6, 8'h00);
    // Drop flags left by the direction changes
    io(4'h8, 4'h8, 8'h03);
    extVal[0] = 1;
    w8;
    chk(irqs, 16'h0001);
    rdc(4'h0, 8'h87);
    io(4'h8, 4'h8, 8'h00);
    rdc(4'h8, 8'h01);
    io(4'h8, 4'h8, 8'h01);
    chk(irqs, 16'h0000);
    extVal[9] = 1;
    w8;
    chk(irqs, 16'h0000);
    extVal[10] = 1;
    w8;
    rdc(4'h8, 8'h02);
    vecEnterUpper = 1;
    @(posedge mclk);
    #1 vecEnterUpper = 0;
    chk(irqs, 16'h0000);
    globalIrqEn = 0;
    extVal[0] = 0;
    w8;
    chk(irqs, 16'h0000);
    globalIrqEn = 1;
    rdc(4'h8, 8'h01);
    chk(irqs, 16'h0001);
    vecEnterLower = 1;
    @(posedge mclk);
    #1 vecEnterLower = 0;
    chk(irqs, 16'h0000);
    altEn = 16'h0002;
    altDrive = 16'h0002;
    @(posedge mclk);
    #1 chk(padOut & ~padOe_n, 16'h0084);
    altEn = 16'h0000;
    arst_n = 0;
    #1 chk(padOe_n, 16'hFFFF);
    results;
  end
endmodule
